/* pwr_mgr_defs.vh */
// Constants for the hub power state manager: system sleep states,
// link power states, device power states and DDR clock-enable power-down timing.
// Assumes inclusion by bare name from the design, checker, model and bench files.
`ifndef PWR_MGR_DEFS_VH
`define PWR_MGR_DEFS_VH

// ----------------------------------------------------------------
// System sleep state codes
// ----------------------------------------------------------------
`define SLP_S0 3'h0
`define SLP_S1 3'h1
`define SLP_S3 3'h3
`define SLP_S4 3'h4
`define SLP_S5 3'h5

// ----------------------------------------------------------------
// Device power state codes of an attached link partner
// ----------------------------------------------------------------
`define DEV_D0 3'h0
`define DEV_D1 3'h1
`define DEV_D2 3'h2
`define DEV_D3HOT 3'h3
`define DEV_D3COLD 3'h4

// ----------------------------------------------------------------
// Link power state codes
// ----------------------------------------------------------------
`define LNK_L0 3'h0
`define LNK_L1 3'h1
`define LNK_L23_RDY 3'h2
`define LNK_L2 3'h3
`define LNK_L3 3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IDLE_PD_CYCLES 16
`define CKE_WAKE_CYCLES 1

`endif

/* cs_idle_ctrl.v */
// One chip select's idle tracker and clock-enable power-down control.
// Assumes access requests come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module cs_idle_ctrl #(
  parameter IDLE_CYCLES = 16
) (
  input wire i_sys_clk,       // Core clock
  input wire i_rst_b,         // Async reset, active low
  input wire i_enable,        // Idle power-down enabled
  input wire i_force_sr,      // Force self refresh (sleep entry)
  input wire i_req,           // New access to this chip select
  output reg o_cke,           // Clock enable to the rank
  output reg o_grant,         // Activate may be issued this cycle
  output reg o_sleeping       // Rank is powered down or in self refresh
);
  localparam CW = 16;
  reg [CW-1:0] idle_cnt_reg;
  reg waking_reg;

  // --------------------------------------------------------------
  // Idle counter and clock enable
  // --------------------------------------------------------------
  // Wake takes exactly one extra clock before the activate is granted
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      idle_cnt_reg <= 16'h0000;
      o_cke <= 1'b1;
      o_grant <= 1'b0;
      o_sleeping <= 1'b0;
      waking_reg <= 1'b0;
    end
    else if (i_force_sr)
    begin
      o_cke <= 1'b0;
      o_sleeping <= 1'b1;
      o_grant <= 1'b0;
      waking_reg <= 1'b0;
    end
    else if (waking_reg)
    begin
      waking_reg <= 1'b0;
      o_grant <= 1'b1;
      idle_cnt_reg <= 16'h0000;
    end
    else if (i_req && !o_cke)
    begin
      o_cke <= 1'b1;
      o_sleeping <= 1'b0;
      waking_reg <= 1'b1;
      o_grant <= 1'b0;
    end
    else if (i_req)
    begin
      o_grant <= 1'b1;
      idle_cnt_reg <= 16'h0000;
    end
    else
    begin
      o_grant <= 1'b0;
      if (i_enable && o_cke)
      begin
        if (idle_cnt_reg == IDLE_CYCLES[CW-1:0] - 16'h0001)
        begin
          o_cke <= 1'b0;
          o_sleeping <= 1'b1;
          idle_cnt_reg <= 16'h0000;
        end
        else
          idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* root_port_link_pm.v */
// Link power state tracker for one root port, following the partner's
// software-set device power state. No autonomous link power saving.
// Assumes the partner's state and handshakes are synchronous inputs.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_mgr_defs.vh"
module root_port_link_pm (
  input wire i_sys_clk,       // Core clock
  input wire i_rst_b,         // Async reset, active low
  input wire [2:0] i_dev_state, // Partner's programmed device state
  input wire i_exit_req,      // Either end requests exit from L1
  input wire i_pwr_off_req,   // Main power removal pending
  input wire i_vaux,          // Auxiliary power present
  output reg [2:0] o_link_state, // Current link power state
  output reg o_l23_ready      // Ready for main power removal
);
  // --------------------------------------------------------------
  // Link state follows device state
  // --------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_link_state <= `LNK_L0;
      o_l23_ready <= 1'b0;
    end
    else
    begin
      case (o_link_state)
        `LNK_L0:
        begin
          if (i_pwr_off_req)
            o_link_state <= `LNK_L23_RDY;
          else if (i_dev_state != `DEV_D0)
            o_link_state <= `LNK_L1;
        end
        `LNK_L1:
        begin
          if (i_pwr_off_req)
            o_link_state <= `LNK_L23_RDY;
          else if (i_exit_req || i_dev_state == `DEV_D0)
            o_link_state <= `LNK_L0;
        end
        `LNK_L23_RDY:
        begin
          o_l23_ready <= 1'b1;
          o_link_state <= i_vaux ? `LNK_L2 : `LNK_L3;
        end
        `LNK_L2, `LNK_L3:
          o_link_state <= o_link_state; // Left only by a full reset
        default:
          o_link_state <= `LNK_L0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* hub_power_state_manager.v */
// Top of the hub power state manager: sleep state sequencing,
// DDR idle power-down per chip select and root port link states.
// Assumes all inputs are from logic on i_sys_clk except i_s3_req_pin.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_mgr_defs.vh"
module hub_power_state_manager #(
  parameter NUM_CS = 4,
  parameter NUM_PORTS = 2,
  parameter IDLE_CYCLES = `IDLE_PD_CYCLES
) (
  input wire i_sys_clk,                  // Core clock, 250 MHz
  input wire i_rst_b,                    // Hard reset, active low
  input wire i_s3_req_pin,               // Sleep entry request from I/O hub (target set by i_sleep_target)
  input wire [2:0] i_sleep_target,       // Requested system state
  input wire i_idle_pd_en,               // Firmware enable for idle power-down
  input wire i_dual_channel,             // Lock-step dual channel mode
  input wire [NUM_CS-1:0] i_cs_req_a,    // Access per chip select, channel A
  input wire [NUM_CS-1:0] i_cs_req_b,    // Access per chip select, channel B
  input wire [NUM_CS-1:0] i_rank_present, // Populated ranks
  input wire i_wbuf_empty,               // Coherent write buffer empty
  input wire [1:0] i_cpu_cstate_req,     // Processor C-state message
  input wire [3*NUM_PORTS-1:0] i_dev_state, // Device state per port
  input wire [NUM_PORTS-1:0] i_l1_exit_req, // L1 exit per port
  input wire i_vaux,                     // Auxiliary power present
  output reg o_wbuf_flush,               // Flush write buffer
  output reg [NUM_CS-1:0] o_cke_a,       // Clock enables, channel A
  output reg [NUM_CS-1:0] o_cke_b,       // Clock enables, channel B
  output reg [NUM_CS-1:0] o_grant_a,     // Activate allowed, channel A
  output reg [NUM_CS-1:0] o_grant_b,     // Activate allowed, channel B
  output reg o_s3_ack,                   // S3 entry acknowledged
  output reg o_sr_hold,                  // DIMMs held in self refresh
  output reg [2:0] o_sys_state,          // Current system state
  output reg o_hub_link_lp,              // Hub link low power (always 0)
  output reg o_cpu_bus_lp,               // Processor bus low power (always 0)
  output reg [1:0] o_cpu_cstate_msg,     // Relayed C-state message
  output reg [3*NUM_PORTS-1:0] o_dev_state_msg, // Device state message
  output reg [3*NUM_PORTS-1:0] o_link_state, // Link state per port
  output reg o_autonomous_link_power_saving_en,                  // Autonomous link power (always 0)
  output reg o_refclk_gate               // Shared reference clock gate
);
  // --------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------
  localparam ST_RUN = 3'h0;
  localparam ST_FLUSH = 3'h1;
  localparam ST_SR = 3'h2;
  localparam ST_SUSP = 3'h3;
  localparam ST_OFF = 3'h4;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg s3_sync1_reg;
  reg s3_sync2_reg;
  reg s3_sync3_reg;
  reg s3_level_reg;
  wire force_sr;
  wire [NUM_CS-1:0] cke_a_w;
  wire [NUM_CS-1:0] cke_b_w;
  wire [NUM_CS-1:0] grant_a_w;
  wire [NUM_CS-1:0] grant_b_w;
  wire [NUM_CS-1:0] slp_a_w;
  wire [NUM_CS-1:0] slp_b_w;
  wire [NUM_CS-1:0] req_b_eff;
  wire [3*NUM_PORTS-1:0] link_w;
  wire sr_done;
  wire pwr_off_req;

  // --------------------------------------------------------------
  // Request synchroniser
  // --------------------------------------------------------------
  // Pin is asynchronous; level changes once stages two and three agree
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s3_sync1_reg <= 1'b0;
      s3_sync2_reg <= 1'b0;
      s3_sync3_reg <= 1'b0;
      s3_level_reg <= 1'b0;
    end
    else
    begin
      s3_sync1_reg <= i_s3_req_pin;
      s3_sync2_reg <= s3_sync1_reg;
      s3_sync3_reg <= s3_sync2_reg;
      if (s3_sync2_reg == s3_sync3_reg)
        s3_level_reg <= s3_sync3_reg;
    end
  end

  // --------------------------------------------------------------
  // DDR chip select control
  // --------------------------------------------------------------
  // In dual-channel mode both channels take channel A's and B's requests ORed
  assign req_b_eff = i_dual_channel ? (i_cs_req_a | i_cs_req_b) : i_cs_req_b;
  assign force_sr = (state_reg == ST_SR) || (state_reg == ST_SUSP);

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g = g + 1)
    begin : gen_cs
      wire req_a_g;
      assign req_a_g = i_dual_channel ? (i_cs_req_a[g] | i_cs_req_b[g]) : i_cs_req_a[g];
      cs_idle_ctrl #(
        .IDLE_CYCLES(IDLE_CYCLES)
      ) u_cs_a (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_enable(i_idle_pd_en),
        .i_force_sr(force_sr),
        .i_req(req_a_g),
        .o_cke(cke_a_w[g]),
        .o_grant(grant_a_w[g]),
        .o_sleeping(slp_a_w[g])
      );
      cs_idle_ctrl #(
        .IDLE_CYCLES(IDLE_CYCLES)
      ) u_cs_b (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_enable(i_idle_pd_en),
        .i_force_sr(force_sr),
        .i_req(req_b_eff[g]),
        .o_cke(cke_b_w[g]),
        .o_grant(grant_b_w[g]),
        .o_sleeping(slp_b_w[g])
      );
    end
  endgenerate

  // Self refresh done when every populated rank on both channels sleeps
  assign sr_done = &((slp_a_w & slp_b_w) | ~i_rank_present);

  // --------------------------------------------------------------
  // Root port link state trackers
  // --------------------------------------------------------------
  assign pwr_off_req = (state_reg != ST_RUN);

  generate
    for (g = 0; g < NUM_PORTS; g = g + 1)
    begin : gen_port
      root_port_link_pm u_link (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_dev_state(i_dev_state[3*g+2:3*g]),
        .i_exit_req(i_l1_exit_req[g]),
        .i_pwr_off_req(pwr_off_req),
        .i_vaux(i_vaux),
        .o_link_state(link_w[3*g+2:3*g]),
        .o_l23_ready()
      );
    end
  endgenerate

  // --------------------------------------------------------------
  // Sleep sequencer next state
  // --------------------------------------------------------------
  // Suspended and off states are left only through the hard reset
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (s3_level_reg)
        begin
          // S1 stays in run; only an S3 target starts the flush
          if (i_sleep_target == `SLP_S4 || i_sleep_target == `SLP_S5)
            state_next = ST_OFF;
          else if (i_sleep_target == `SLP_S3)
            state_next = ST_FLUSH;
        end
      end
      ST_FLUSH:
        if (i_wbuf_empty)
          state_next = ST_SR;
      ST_SR:
        if (sr_done)
          state_next = ST_SUSP;
      ST_SUSP:
        state_next = ST_SUSP;
      ST_OFF:
        state_next = ST_OFF;
      default:
        state_next = ST_RUN;
    endcase
  end

  // --------------------------------------------------------------
  // Sequencer state and registered outputs
  // --------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_RUN;
      o_wbuf_flush <= 1'b0;
      o_cke_a <= {NUM_CS{1'b1}};
      o_cke_b <= {NUM_CS{1'b1}};
      o_grant_a <= {NUM_CS{1'b0}};
      o_grant_b <= {NUM_CS{1'b0}};
      o_s3_ack <= 1'b0;
      o_sr_hold <= 1'b0;
      o_sys_state <= `SLP_S0;
      o_hub_link_lp <= 1'b0;
      o_cpu_bus_lp <= 1'b0;
      o_cpu_cstate_msg <= 2'h0;
      o_dev_state_msg <= {3*NUM_PORTS{1'b0}};
      o_link_state <= {3*NUM_PORTS{1'b0}};
      o_autonomous_link_power_saving_en <= 1'b0;
      o_refclk_gate <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      o_wbuf_flush <= (state_next == ST_FLUSH);
      o_cke_a <= cke_a_w;
      o_cke_b <= cke_b_w;
      o_grant_a <= grant_a_w;
      o_grant_b <= grant_b_w;
      o_s3_ack <= (state_next == ST_SUSP);
      o_sr_hold <= (state_next == ST_SUSP);
      if (state_next == ST_SUSP)
        o_sys_state <= `SLP_S3;
      else if (state_next == ST_OFF)
      begin
        // Captured on entry only, so a later target change cannot move it
        if (state_reg == ST_RUN)
          o_sys_state <= i_sleep_target;
      end
      else if (s3_level_reg && i_sleep_target == `SLP_S1)
        o_sys_state <= `SLP_S1;
      else
        o_sys_state <= `SLP_S0;
      o_hub_link_lp <= 1'b0;
      o_cpu_bus_lp <= 1'b0;
      o_cpu_cstate_msg <= i_cpu_cstate_req;
      o_dev_state_msg <= i_dev_state;
      o_link_state <= link_w;
      o_autonomous_link_power_saving_en <= 1'b0;
      // Reference clock is shared by all ports, gated from the cycle after the sequencer becomes suspended or off
      o_refclk_gate <= (state_reg == ST_OFF) || (state_reg == ST_SUSP);
    end
  end
endmodule
`default_nettype wire

/* hub_power_state_manager_assertions.sv */
// Checker for the hub power state manager, watching top ports only.
// Assumes a bind from the bench; one clock domain, async reset.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_mgr_defs.vh"
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module hub_power_checker #(
  parameter NUM_CS = 4,
  parameter NUM_PORTS = 2,
  parameter IDLE_CYCLES = 16
) (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_s3_req_pin, // Sleep request pin
  input wire logic i_idle_pd_en, // Idle power-down enable
  input wire logic i_dual_channel, // Lock-step mode
  input wire logic [NUM_CS-1:0] i_cs_req_a, // Requests, channel A
  input wire logic [NUM_CS-1:0] i_cs_req_b, // Requests, channel B
  input wire logic [NUM_CS-1:0] i_rank_present, // Populated ranks
  input wire logic i_wbuf_empty, // Write buffer empty
  input wire logic [1:0] i_cpu_cstate_req, // C-state message in
  input wire logic [3*NUM_PORTS-1:0] i_dev_state, // Device states
  input wire logic [NUM_PORTS-1:0] i_l1_exit_req, // L1 exit
  input wire logic [NUM_CS-1:0] o_cke_a, // Clock enables A
  input wire logic [NUM_CS-1:0] o_cke_b, // Clock enables B
  input wire logic [NUM_CS-1:0] o_grant_a, // Grants A
  input wire logic [NUM_CS-1:0] o_grant_b, // Grants B
  input wire logic o_s3_ack, // Sleep acknowledge
  input wire logic o_sr_hold, // Self refresh hold
  input wire logic [2:0] o_sys_state, // System state
  input wire logic o_hub_link_lp, // Hub link low power
  input wire logic o_cpu_bus_lp, // Processor bus low power
  input wire logic [1:0] o_cpu_cstate_msg, // C-state message out
  input wire logic [3*NUM_PORTS-1:0] o_link_state, // Link states
  input wire logic o_autonomous_link_power_saving_en, // Autonomous link saving
  input wire logic o_refclk_gate // Shared refclk gate
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] idle_cnt;
  // Idle run length of chip select 0; saturates so it never wraps
  always @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
      idle_cnt <= 8'h00;
    else if (!i_idle_pd_en || i_cs_req_a[0] || i_cs_req_b[0])
      idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff)
      idle_cnt <= idle_cnt + 8'h01;
  sequence s_d1_steady;
    (i_dev_state[2:0] == `DEV_D1 && !i_l1_exit_req[0] && !i_s3_req_pin && o_sys_state == `SLP_S0) [*4];
  endsequence
  sequence s_sleep_done;
    $rose(o_s3_ack);
  endsequence
  property p_hub_link; o_hub_link_lp == 1'b0; endproperty
  property p_cpu_bus; o_cpu_bus_lp == 1'b0; endproperty
  property p_no_autonomous_link_power_saving; o_autonomous_link_power_saving_en == 1'b0; endproperty
  property p_cstate; 1'b1 |=> o_cpu_cstate_msg == $past(i_cpu_cstate_req); endproperty
  property p_idle_pd; idle_cnt > IDLE_CYCLES + 3 |-> !o_cke_a[0] && !o_cke_b[0]; endproperty
  property p_grant_cke; o_grant_a[0] |-> o_cke_a[0]; endproperty
  property p_lockstep; i_dual_channel [*4] |-> o_cke_a == o_cke_b && o_grant_a == o_grant_b; endproperty
  property p_ack_order;
    s_sleep_done |-> i_wbuf_empty && (o_cke_a & i_rank_present) == 0 && (o_cke_b & i_rank_present) == 0;
  endproperty
  property p_no_ack_dirty; !i_wbuf_empty |-> !o_s3_ack; endproperty
  property p_sr_hold; o_sr_hold |=> o_sr_hold && (o_cke_a & i_rank_present) == 0; endproperty
  property p_sticky; o_sys_state >= `SLP_S3 |=> $stable(o_sys_state); endproperty
  property p_link_l1; s_d1_steady |-> o_link_state[2:0] == `LNK_L1; endproperty
  property p_refclk; o_refclk_gate |-> o_sys_state >= `SLP_S3; endproperty
  a_hub_link: assert property (p_hub_link) else $error("hub link left full power");
  a_cpu_bus: assert property (p_cpu_bus) else $error("processor bus low power seen");
  a_no_autonomous_link_power_saving: assert property (p_no_autonomous_link_power_saving) else $error("autonomous link saving on");
  a_cstate: assert property (p_cstate) else $error("C-state message not relayed");
  a_idle_pd: assert property (p_idle_pd) else $error("idle rank kept its clock");
  a_grant_cke: assert property (p_grant_cke) else $error("grant while clock off");
  a_lockstep: assert property (p_lockstep) else $error("channels out of step");
  a_ack_order: assert property (p_ack_order) else $error("ack before flush and refresh");
  a_no_ack_dirty: assert property (p_no_ack_dirty) else $error("ack with dirty buffer");
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh hold dropped");
  a_sticky: assert property (p_sticky) else $error("left deep sleep without reset");
  a_link_l1: assert property (p_link_l1) else $error("link not in L1 for D1");
  a_refclk: assert property (p_refclk) else $error("refclk gated while running");
endmodule
`default_nettype wire

/* hub_far_side_model.sv */
// Far side model: write buffer drain and attached device state.
// Assumes flush and state commands arrive on the core clock.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_mgr_defs.vh"
// ----------------------------------------------------------------
// Partner model
// ----------------------------------------------------------------
module hub_far_side_model (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_flush, // Flush request from the hub
  input wire logic i_slow, // Slow drain when high
  input wire logic [2:0] i_dev_cmd, // Software-set device state
  output logic o_wbuf_empty, // Buffer drained
  output logic [2:0] o_dev_state, // Device state seen by the hub
  output logic o_ctx_lost, // Context lost in a D3 state
  output logic o_flush_seen // Flush was requested
);
  logic [3:0] drain_cnt;
  // Buffer starts dirty so an early acknowledge would be caught
  always @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      drain_cnt <= 4'h0;
      o_wbuf_empty <= 1'b0;
      o_dev_state <= `DEV_D0;
      o_ctx_lost <= 1'b0;
      o_flush_seen <= 1'b0;
    end
    else
    begin
      o_dev_state <= i_dev_cmd;
      if (i_dev_cmd >= `DEV_D3HOT)
        o_ctx_lost <= 1'b1;
      if (i_flush)
      begin
        o_flush_seen <= 1'b1;
        if (drain_cnt == (i_slow ? 4'hc : 4'h2))
          o_wbuf_empty <= 1'b1;
        else
          drain_cnt <= drain_cnt + 4'h1;
      end
    end
endmodule
`default_nettype wire

/* hub_power_state_manager_bench.sv */
// Self-checking bench for the hub power state manager.
// Assumes the checker and far side model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_mgr_defs.vh"
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module hub_power_state_manager_bench;
  localparam IDLE = 4;
  typedef struct {logic [2:0] dev; logic [1:0] cst; logic [2:0] lnk;} row_t;
  logic i_sys_clk, i_rst_b, i_s3_req_pin, i_idle_pd_en, i_dual_channel, i_vaux, i_slow, i_wbuf_empty;
  logic o_wbuf_flush, o_s3_ack, o_sr_hold, o_hub_link_lp, o_cpu_bus_lp, o_autonomous_link_power_saving_en, o_refclk_gate;
  logic [2:0] i_sleep_target, dev_cmd, dev0, o_sys_state;
  logic [3:0] i_cs_req_a, i_cs_req_b, i_rank_present, o_cke_a, o_cke_b, o_grant_a, o_grant_b;
  logic [1:0] i_cpu_cstate_req, o_cpu_cstate_msg, i_l1_exit_req;
  logic [5:0] i_dev_state, o_dev_state_msg, o_link_state;
  logic flush_seen, ctx_lost;
  int miscompares = 0, checks_done = 0, n, lat_awake, lat_sleep;
  // Port 0 walks every device state; 3'h7 marks a link left unchecked
  row_t rows[5] = '{'{`DEV_D0, 2'h0, `LNK_L0}, '{`DEV_D1, 2'h1, `LNK_L1}, '{`DEV_D2, 2'h3, `LNK_L1},
    '{`DEV_D3HOT, 2'h0, `LNK_L1}, '{`DEV_D3COLD, 2'h1, 3'h7}};
  assign i_dev_state = {`DEV_D0, dev0};
  hub_power_state_manager #(.IDLE_CYCLES(IDLE)) i_hub_power_state_manager (.*);
  hub_far_side_model i_hub_far_side_model (.i_sys_clk, .i_rst_b, .i_flush(o_wbuf_flush), .i_slow,
    .i_dev_cmd(dev_cmd), .o_wbuf_empty(i_wbuf_empty), .o_dev_state(dev0), .o_ctx_lost(ctx_lost),
    .o_flush_seen(flush_seen));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task step(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (miscompares == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Requests and controls quiet, dual channel on, all ranks present, reset held two cycles
  task do_reset;
    i_rst_b = 1'b0;
    {i_s3_req_pin, i_idle_pd_en, i_vaux, i_slow, i_l1_exit_req, i_cpu_cstate_req} = 8'h00;
    {i_cs_req_a, i_cs_req_b} = 8'h00;
    i_dual_channel = 1'b1;
    i_rank_present = 4'hf;
    i_sleep_target = `SLP_S0;
    dev_cmd = `DEV_D0;
    step(2);
    i_rst_b = 1'b1;
  endtask
  // Cycles from request to grant on chip select 0
  task measure(output int lat);
    i_cs_req_a[0] = 1'b1;
    lat = 0;
    step(1);
    while (o_grant_a[0] !== 1'b1 && lat < 20)
    begin
      lat++;
      step(1);
    end
    check(o_grant_b[0], 8'h01);
    i_cs_req_a[0] = 1'b0;
    step(2);
  endtask
  initial
  begin
    #100000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    do_reset;
    step(1);
    check({o_cke_a, o_cke_b}, 8'hff);
    check({o_s3_ack, o_sr_hold, o_wbuf_flush, o_refclk_gate, o_sys_state}, 8'h00);
    foreach (rows[k])
    begin
      dev_cmd = rows[k].dev;
      i_cpu_cstate_req = rows[k].cst;
      step(6);
      check(o_cpu_cstate_msg, rows[k].cst);
      check(o_dev_state_msg[2:0], rows[k].dev);
      if (rows[k].lnk != 3'h7)
        check(o_link_state[2:0], rows[k].lnk);
    end
    dev_cmd = `DEV_D1;
    step(6);
    i_l1_exit_req = 2'b01;
    step(4);
    check(o_link_state[2:0], `LNK_L0);
    i_l1_exit_req = 2'b00;
    dev_cmd = `DEV_D0;
    step(6);
    measure(lat_awake);
    i_idle_pd_en = 1'b1;
    step(IDLE + 6);
    check({o_cke_a, o_cke_b}, 8'h00);
    measure(lat_sleep);
    check(8'(lat_sleep), 8'(lat_awake + 1));
    i_sleep_target = `SLP_S1;
    i_s3_req_pin = 1'b1;
    for (n = 0; o_sys_state !== `SLP_S1 && n < 20; n++)
      step(1);
    check(o_sys_state, `SLP_S1);
    i_s3_req_pin = 1'b0;
    for (n = 0; o_sys_state !== `SLP_S0 && n < 20; n++)
      step(1);
    check(o_sys_state, `SLP_S0);
    // Aux power present then absent; drain slow then prompt
    for (int v = 1; v >= 0; v--)
    begin
      do_reset;
      i_vaux = v[0];
      i_slow = v[0];
      i_sleep_target = `SLP_S3;
      i_s3_req_pin = 1'b1;
      for (n = 0; o_s3_ack !== 1'b1 && n < 300; n++)
        step(1);
      check({flush_seen, o_sr_hold, o_cke_a, o_cke_b}, 10'h300);
      check(o_sys_state, `SLP_S3);
      for (n = 0; o_link_state[2:0] !== (v ? `LNK_L2 : `LNK_L3) && n < 50; n++)
        step(1);
      check(o_link_state[2:0], v ? `LNK_L2 : `LNK_L3);
      i_s3_req_pin = 1'b0;
      i_sleep_target = `SLP_S0;
      step(20);
      check({o_sr_hold, o_cke_a, o_cke_b, o_sys_state}, 12'h803);
      check(o_sys_state, `SLP_S3);
    end
    do_reset;
    step(1);
    check(o_sys_state, `SLP_S0);
    // Soft off: state taken on entry, kept when the target changes
    i_sleep_target = `SLP_S5;
    i_s3_req_pin = 1'b1;
    step(8);
    i_sleep_target = `SLP_S0;
    step(4);
    check({o_sys_state, o_refclk_gate, o_s3_ack}, {`SLP_S5, 2'b10});
    end_sim;
  end
endmodule
bind hub_power_state_manager hub_power_checker #(.NUM_CS(NUM_CS), .NUM_PORTS(NUM_PORTS),
  .IDLE_CYCLES(IDLE_CYCLES)) i_hub_power_checker (.*);
`default_nettype wire
